// ===== design/adc_readout_pkg.sv
/*
 * Shared constants and types for the dual-channel converter readout:
 * sample widths, frame layout, power-down pulse counts, buffer depth.
 * Assumes nothing of its surroundings; imported whole by pair_fifo, adc_readout and the bench.
 */
`default_nettype none

package adc_readout_pkg;

    // ------------------------------------------------------------
    // sample and frame layout
    // ------------------------------------------------------------
    localparam int unsigned SAMPLE_W   = 14;
    localparam int unsigned PAIR_W     = 2 * SAMPLE_W;
    localparam int unsigned PAD_W      = 2;
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned CNT_W      = 6;
    localparam logic [PAD_W-1:0] PAD_BITS   = 2'h0;   // leading zeros of each word
    localparam logic [CNT_W-1:0] FRAME_LAST = 6'h20;  // edge count that closes a frame
    localparam logic [CNT_W-1:0] CNT_ONE    = 6'h01;

    // ------------------------------------------------------------
    // power-down control
    // ------------------------------------------------------------
    localparam logic [2:0] LIGHT_PULSES = 3'h2;
    localparam logic [2:0] DEEP_PULSES  = 3'h4;

    // ------------------------------------------------------------
    // buffering
    // ------------------------------------------------------------
    localparam int unsigned FIFO_DEPTH = 16;

    typedef enum logic [2:0]
    {
        PWR_ACTIVE = 3'b001,
        PWR_LIGHT  = 3'b010,
        PWR_DEEP   = 3'b100
    } power_t;

    // a toggle crossing reports an event when the synced copy moves
    function automatic logic toggled(input logic now_v, input logic last_v);
        return now_v ^ last_v;
    endfunction

endpackage

`default_nettype wire

// ===== design/pair_stream_if.sv
/*
 * Valid/ready carrier between the sample capture logic and the pair buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface pair_stream_if #(parameter int unsigned W = 28);
    logic [W-1:0] in_data;
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] out_data;
    logic         out_valid;
    logic         out_ready;

    modport user  (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
    modport store (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
endinterface

`default_nettype wire

// ===== design/pair_fifo.sv
/*
 * Synchronous FIFO for captured sample pairs, width and depth as parameters.
 * Assumes one clock for both sides and a synchronous active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none

module pair_fifo
    import adc_readout_pkg::*;
#(
    parameter int unsigned W     = PAIR_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
)
(
    input  wire logic    clk_sys,
    input  wire logic    rst_n,
    pair_stream_if.store port_if
);

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wr;
        logic [AW:0]             rd;
    } fifo_state_t;

    fifo_state_t s_reg;
    fifo_state_t s_next;
    logic        full;
    logic        empty;

    // ------------------------------------------------------------
    // flags: the extra pointer bit tells full from empty
    // ------------------------------------------------------------
    assign empty = (s_reg.wr == s_reg.rd);
    assign full  = (s_reg.wr[AW] != s_reg.rd[AW]) && (s_reg.wr[AW-1:0] == s_reg.rd[AW-1:0]);
    assign port_if.in_ready  = !full;
    assign port_if.out_valid = !empty;
    assign port_if.out_data  = s_reg.mem[s_reg.rd[AW-1:0]];

    // next state: write and read may happen in the same cycle
    always_comb
    begin
        s_next = s_reg;
        if (port_if.in_valid && !full)
        begin
            s_next.mem[s_reg.wr[AW-1:0]] = port_if.in_data;
            s_next.wr = s_reg.wr + 1'b1;
        end
        if (port_if.out_ready && !empty)
        begin
            s_next.rd = s_reg.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

endmodule

`default_nettype wire

// ===== design/adc_readout.sv
/*
 * Digital control of a dual-channel simultaneous-sampling converter:
 * strobe capture, power-down sequencing on clk_sys, and the serial result
 * frame on the link clock sck_clk. Assumes the strobe pin is held at least
 * two clk_sys periods per level and that sck_clk runs during reset.
 */
`timescale 1ns/1ns
`default_nettype none

module adc_readout
    import adc_readout_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                sck_clk,
    input  wire logic                conversion_start_strobe,
    input  wire logic [SAMPLE_W-1:0] first_diff_input,
    input  wire logic [SAMPLE_W-1:0] second_diff_input,
    output logic                     sdo_out,
    output logic                     sdo_oe_n,
    output logic                     converting,
    output logic                     acquiring,
    output logic                     light_pd,
    output logic                     deep_pd,
    output logic                     ref_powered
);

    // ------------------------------------------------------------
    // system-clock state
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic                strb_meta;
        logic                strb_sync;
        logic                strb_last;
        logic [SAMPLE_W-1:0] a_meta;
        logic [SAMPLE_W-1:0] a_sync;
        logic [SAMPLE_W-1:0] b_meta;
        logic [SAMPLE_W-1:0] b_sync;
        logic [PAIR_W-1:0]   held;
        logic                push;
        logic                busy;
        logic [2:0]          pulses;
        power_t              power;
        logic [PAIR_W-1:0]   xfer_word;
        logic                xfer_tog;
        logic                wait_ack;
        logic                sck_meta;
        logic                sck_sync;
        logic                sck_last;
        logic                ack_meta;
        logic                ack_sync;
        logic                ack_last;
        logic                light_pd;
        logic                deep_pd;
        logic                ref_on;
    } sys_state_t;

    // ------------------------------------------------------------
    // link-clock state
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic                  rst_meta;
        logic                  rst_sync;
        logic                  xfer_meta;
        logic                  xfer_sync;
        logic                  xfer_last;
        logic [PAIR_W-1:0]     conversion_start_strobe_word;
        logic [FRAME_BITS-1:0] shift;
        logic [CNT_W-1:0]      bit_cnt;
        logic                  framing;
        logic                  done_tog;
        logic                  act_tog;
        logic                  act_echo_meta;
        logic                  act_echo_sync;
        logic                  sdo;
        logic                  oe_n;
        logic                  acq;
    } link_state_t;

    sys_state_t  s_reg;
    sys_state_t  s_next;
    link_state_t l_reg;
    link_state_t l_next;

    pair_stream_if #(.W(PAIR_W)) buf_if ();

    logic conversion_start_strobe_rise;
    logic sck_seen;
    logic ack_seen;
    logic start_seen;

    // ------------------------------------------------------------
    // pair buffer between capture and the link handshake
    // ------------------------------------------------------------
    pair_fifo #(.W(PAIR_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .port_if (buf_if.store)
    );

    // push side is fed from the held pair; drain stalls while a word is in flight
    assign buf_if.in_data   = s_reg.held;
    assign buf_if.in_valid  = s_reg.push;
    assign buf_if.out_ready = !s_reg.wait_ack;

    // event decode on the system side
    assign conversion_start_strobe_rise = s_reg.strb_sync & ~s_reg.strb_last;
    assign sck_seen  = toggled(s_reg.sck_sync, s_reg.sck_last);
    assign ack_seen  = toggled(s_reg.ack_sync, s_reg.ack_last);

    // ------------------------------------------------------------
    // system clock: capture, power state, hand-off to the link
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        // two-stage synchronisers for pins and link toggles
        s_next.strb_meta = conversion_start_strobe;
        s_next.strb_sync = s_reg.strb_meta;
        s_next.strb_last = s_reg.strb_sync;
        s_next.a_meta    = first_diff_input;
        s_next.a_sync    = s_reg.a_meta;
        s_next.b_meta    = second_diff_input;
        s_next.b_sync    = s_reg.b_meta;
        s_next.sck_meta  = l_reg.act_tog;
        s_next.sck_sync  = s_reg.sck_meta;
        s_next.sck_last  = s_reg.sck_sync;
        s_next.ack_meta  = l_reg.done_tog;
        s_next.ack_sync  = s_reg.ack_meta;
        s_next.ack_last  = s_reg.ack_sync;

        // power state: link activity always wins over a strobe in the same cycle
        if (sck_seen)
        begin
            s_next.pulses = 3'h0;
            s_next.power  = PWR_ACTIVE;
        end
        else if (conversion_start_strobe_rise)
        begin
            if (s_reg.pulses != DEEP_PULSES)
            begin
                s_next.pulses = s_reg.pulses + 3'h1;
            end
            if (s_next.pulses == DEEP_PULSES)
            begin
                s_next.power = PWR_DEEP;
            end
            else if (s_next.pulses == LIGHT_PULSES)
            begin
                s_next.power = PWR_LIGHT;
            end
        end

        // start: only when active, idle and the buffer can take the pair
        if (conversion_start_strobe_rise && !s_reg.busy && s_reg.power == PWR_ACTIVE && buf_if.in_ready)
        begin
            s_next.held = {s_reg.a_sync, s_reg.b_sync};
            s_next.push = 1'b1;
            s_next.busy = 1'b1;
        end
        else if (s_reg.push && buf_if.in_ready)
        begin
            s_next.push = 1'b0;
        end

        // loader: one word in flight; its return toggle frees the next start
        if (buf_if.out_valid && !s_reg.wait_ack)
        begin
            s_next.xfer_word = buf_if.out_data;
            s_next.xfer_tog  = ~s_reg.xfer_tog;
            s_next.wait_ack  = 1'b1;
        end
        else if (ack_seen)
        begin
            s_next.wait_ack = 1'b0;
        end
        if (ack_seen)
        begin
            s_next.busy = 1'b0;
        end

        // registered status outputs follow the next power state
        s_next.light_pd = (s_next.power == PWR_LIGHT);
        s_next.deep_pd  = (s_next.power == PWR_DEEP);
        s_next.ref_on   = (s_next.power != PWR_DEEP);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_reg        <= '0;
            s_reg.power  <= PWR_ACTIVE;
            s_reg.ref_on <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // link clock: frame sequencing and serial output
    // ------------------------------------------------------------
    // the word crossing is a toggle handshake; xfer_word is stable until the
    // ack returns, so it is read without its own synchroniser
    assign start_seen = toggled(l_reg.xfer_sync, l_reg.xfer_last);

    always_comb
    begin
        l_next = l_reg;
        l_next.rst_meta  = rst_n;
        l_next.rst_sync  = l_reg.rst_meta;
        l_next.xfer_meta = s_reg.xfer_tog;
        l_next.xfer_sync = l_reg.xfer_meta;
        l_next.xfer_last = l_reg.xfer_sync;
        l_next.act_echo_meta = s_reg.sck_sync;
        l_next.act_echo_sync = l_reg.act_echo_meta;
        // activity toggle waits for its echo, so a burst of fast edges can
        // never cancel out between two system-clock samples
        if (l_reg.act_echo_sync == l_reg.act_tog)
        begin
            l_next.act_tog = ~l_reg.act_tog;
        end

        if (!l_reg.rst_sync)
        begin
            l_next.xfer_last = l_reg.xfer_sync;
            l_next.conversion_start_strobe_word = '0;
            l_next.shift     = '0;
            l_next.bit_cnt   = '0;
            l_next.framing   = 1'b0;
            l_next.done_tog  = 1'b0;
            l_next.act_tog   = 1'b0;
            l_next.sdo       = 1'b0;
            l_next.oe_n      = 1'b1;
            l_next.acq       = 1'b1;
        end
        else if (start_seen && !l_reg.framing)
        begin
            // previous conversion goes out; the new pair enters conversion
            l_next.shift = {PAD_BITS, l_reg.conversion_start_strobe_word[PAIR_W-1:SAMPLE_W],
                            PAD_BITS, l_reg.conversion_start_strobe_word[SAMPLE_W-1:0]} << 1;
            l_next.sdo       = 1'b0;                     // first pad bit
            l_next.conversion_start_strobe_word = s_reg.xfer_word;
            l_next.oe_n      = 1'b0;
            l_next.bit_cnt   = CNT_ONE;
            l_next.framing   = 1'b1;
            l_next.acq       = 1'b0;
        end
        else if (l_reg.framing)
        begin
            l_next.sdo     = l_reg.shift[FRAME_BITS-1];
            l_next.shift   = l_reg.shift << 1;
            l_next.bit_cnt = l_reg.bit_cnt + CNT_ONE;
            if (l_next.bit_cnt == FRAME_LAST)
            begin
                // 32nd edge: last bit out, acquisition opens, start freed
                l_next.framing  = 1'b0;
                l_next.acq      = 1'b1;
                l_next.done_tog = ~l_reg.done_tog;
            end
        end
        else
        begin
            l_next.oe_n = 1'b1;                          // released after the frame
        end
    end

    // link clock may stop between frames; the oe_n release waits for the edge after the 32nd
    always_ff @(posedge sck_clk)
    begin
        l_reg <= l_next;
    end

    // ------------------------------------------------------------
    // outputs, each taken straight from a flip-flop
    // ------------------------------------------------------------
    assign sdo_out     = l_reg.sdo;
    assign sdo_oe_n    = l_reg.oe_n;
    assign acquiring   = l_reg.acq;
    assign converting  = s_reg.busy;
    assign light_pd    = s_reg.light_pd;
    assign deep_pd     = s_reg.deep_pd;
    assign ref_powered = s_reg.ref_on;

endmodule

`default_nettype wire

// ===== bench/adc_readout_asserts.sv
/* Port-level checks of the converter readout, both clock domains.
   Assumes rst_n resets both domains and sck_clk runs during reset. */
`timescale 1ns/1ns
`default_nettype none

module adc_readout_asserts
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sck_clk,
    input wire logic conversion_start_strobe,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    input wire logic converting,
    input wire logic acquiring,
    input wire logic light_pd,
    input wire logic deep_pd,
    input wire logic ref_powered
);
    // ----------------------------------------
    // frame position, sck domain
    // ----------------------------------------
    logic [5:0] oe_cnt;

    // edges sampled with the driver on; a stuck enable shows as an overrun
    always_ff @(posedge sck_clk)
    begin
        if (!rst_n || sdo_oe_n)
            oe_cnt <= 6'h00;
        else
            oe_cnt <= oe_cnt + 6'h01;
    end

    sequence s_start_taken;
        $rose(conversion_start_strobe) && !converting && !light_pd && !deep_pd;
    endsequence

    sequence s_frame_close;
        !sdo_oe_n ##1 sdo_oe_n;
    endsequence

    // ----------------------------------------
    // start and power-down control, clk_sys domain
    // ----------------------------------------
    a_reset_active: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(rst_n) |-> !converting && !light_pd && !deep_pd && ref_powered)
        else $error("device not active after reset");
    a_start_accept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_start_taken |-> ##[2:5] converting)
        else $error("strobe rise did not start a conversion");
    a_start_active: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(converting) |-> !light_pd && !deep_pd)
        else $error("conversion started in power-down");
    a_pd_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(light_pd && deep_pd))
        else $error("light and deep power-down together");
    a_deep_after_light: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(deep_pd) |-> $past(light_pd))
        else $error("deep power-down without passing light");
    a_ref_in_light: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ref_powered != deep_pd)
        else $error("reference power wrong for state");

    // ----------------------------------------
    // serial frame, sck domain
    // ----------------------------------------
    a_frame_length: assert property (@(posedge sck_clk) disable iff (!rst_n)
        $rose(sdo_oe_n) |-> oe_cnt == 6'h20)
        else $error("frame not 32 bits long");
    a_frame_bound: assert property (@(posedge sck_clk) disable iff (!rst_n)
        !sdo_oe_n |-> oe_cnt <= 6'h1f)
        else $error("output driven past frame end");
    a_pad_zero: assert property (@(posedge sck_clk) disable iff (!rst_n)
        !sdo_oe_n && (oe_cnt inside {6'h00, 6'h01, 6'h10, 6'h11}) |-> !sdo_out)
        else $error("pad bit not zero");
    a_acq_window: assert property (@(posedge sck_clk) disable iff (!rst_n)
        !sdo_oe_n |-> acquiring == (oe_cnt == 6'h1f))
        else $error("acquiring wrong inside frame");
    a_frame_close: assert property (@(posedge sck_clk) disable iff (!rst_n)
        $rose(acquiring) |-> s_frame_close)
        else $error("output not released after last bit");
endmodule

bind adc_readout adc_readout_asserts u_adc_readout_asserts
(
    .clk_sys                 (clk_sys),
    .rst_n                   (rst_n),
    .sck_clk                 (sck_clk),
    .conversion_start_strobe (conversion_start_strobe),
    .sdo_out                 (sdo_out),
    .sdo_oe_n                (sdo_oe_n),
    .converting              (converting),
    .acquiring               (acquiring),
    .light_pd                (light_pd),
    .deep_pd                 (deep_pd),
    .ref_powered             (ref_powered)
);

`default_nettype wire

// ===== bench/host_serial_model.sv
/* Host serial port model: clocks sck_clk for frame runs and idle bursts, collects bits.
   Assumes the bench calls its tasks; sck_clk stands low between frames. */
`timescale 1ns/1ns
`default_nettype none

module host_serial_model
(
    input  wire logic        sdo_out,
    input  wire logic        sdo_oe_n,
    output var  logic        sck_clk,
    output var  logic [31:0] frame_word,
    output var  logic        frame_valid
);
    initial
    begin
        sck_clk = 1'b0;
        frame_word = 32'h0;
        frame_valid = 1'b0;
    end

    // one 6 ns link period
    task automatic tick;
        #3 sck_clk = 1'b1;
        #3 sck_clk = 1'b0;
    endtask

    task automatic idle_edges(input int n);
        repeat (n) tick();
    endtask

    // a bit is taken just before the edge after the one that put it out
    task automatic run_frame;
        int          got;
        logic [31:0] word;
        got = 0;
        word = 32'h0;
        #2;
        for (int n = 0; n < 80 && !(got == 32 && sdo_oe_n === 1'b1); n++)
        begin
            if (sdo_oe_n === 1'b0 && got < 32)
            begin
                word = {word[30:0], sdo_out};
                got++;
            end
            tick();
        end
        frame_word = word;
        frame_valid = 1'b1;
        #1 frame_valid = 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== bench/adc_readout_tb.sv
/* Self-checking bench: strobe and channel data driven on clk_sys falls,
   frames clocked by the host model. Assumes the bound checker. */
`timescale 1ns/1ns
`default_nettype none

module adc_readout_tb
    import adc_readout_pkg::*;
;
    logic                  clk_sys;
    logic                  rst_n;
    logic                  sck_clk;
    logic                  conversion_start_strobe;
    logic [SAMPLE_W-1:0]   first_diff_input;
    logic [SAMPLE_W-1:0]   second_diff_input;
    logic                  sdo_out;
    logic                  sdo_oe_n;
    logic                  converting;
    logic                  acquiring;
    logic                  light_pd;
    logic                  deep_pd;
    logic                  ref_powered;
    logic [FRAME_BITS-1:0] frame_word;
    logic                  frame_valid;
    logic [FRAME_BITS-1:0] exp_q[$];
    logic [FRAME_BITS-1:0] prev_pair;
    int                    error_cnt;
    int                    checked;
    int                    seed;
    int                    extra_tab[6] = '{0, 1, 2, 3, 4, 0};

    adc_readout u_adc_readout
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .sck_clk(sck_clk),
        .conversion_start_strobe(conversion_start_strobe),
        .first_diff_input(first_diff_input), .second_diff_input(second_diff_input),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .converting(converting),
        .acquiring(acquiring), .light_pd(light_pd), .deep_pd(deep_pd),
        .ref_powered(ref_powered)
    );

    host_serial_model u_host_serial_model
    (
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .sck_clk(sck_clk),
        .frame_word(frame_word), .frame_valid(frame_valid)
    );

    task automatic check_flag(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_frame(input logic [FRAME_BITS-1:0] exp,
                               input logic [FRAME_BITS-1:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected frame: expected %h seen %h", exp, got);
        end
    endtask

    task automatic test_done;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // levels held 3 periods, above the 2-period minimum of the sampler
    task automatic pulse_strobe;
        @(negedge clk_sys);
        conversion_start_strobe = 1'b1;
        repeat (3) @(negedge clk_sys);
        conversion_start_strobe = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic wait_conversion_start_strobe(input logic lvl);
        for (int n = 0; n < 20 && converting !== lvl; n++)
            @(negedge clk_sys);
        check_flag("converting", lvl, converting);
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // frame monitor: oldest note against each frame
    // ----------------------------------------
    initial
    begin
        forever
        begin
            @(posedge frame_valid);
            if (exp_q.size() > 0)
                check_frame(exp_q.pop_front(), frame_word);
            else
                check_frame(32'hffffffff, frame_word);
        end
    end

    initial
    begin
        #200000;
        error_cnt++;
        test_done();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        seed = 26710;
        rst_n = 1'b0;
        conversion_start_strobe = 1'b0;
        first_diff_input = 14'h0000;
        second_diff_input = 14'h0000;
        prev_pair = 32'h0;
        // link edges only once the system side is reset, so the link syncs see 0
        repeat (4) @(negedge clk_sys);
        u_host_serial_model.idle_edges(8);
        @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check_flag("light_pd", 1'b0, light_pd);
        check_flag("ref_powered", 1'b1, ref_powered);
        for (int i = 0; i < 6; i++)
        begin
            first_diff_input = SAMPLE_W'($random(seed));
            second_diff_input = SAMPLE_W'($random(seed));
            pulse_strobe();
            wait_conversion_start_strobe(1'b1);
            exp_q.push_back(prev_pair);
            prev_pair = {PAD_BITS, first_diff_input, PAD_BITS, second_diff_input};
            // refused strobes carry other data, which must never be framed
            first_diff_input = ~first_diff_input;
            second_diff_input = SAMPLE_W'($random(seed));
            for (int k = 0; k < extra_tab[i]; k++)
                pulse_strobe();
            check_flag("light_pd", extra_tab[i] inside {1, 2}, light_pd);
            check_flag("deep_pd", extra_tab[i] >= 3, deep_pd);
            check_flag("ref_powered", extra_tab[i] < 3, ref_powered);
            check_flag("converting", 1'b1, converting);
            u_host_serial_model.run_frame();
            wait_conversion_start_strobe(1'b0);
            repeat (2) @(negedge clk_sys);
            check_flag("deep_pd", 1'b0, deep_pd);
            check_flag("light_pd", 1'b0, light_pd);
            check_flag("acquiring", 1'b1, acquiring);
            check_flag("sdo_oe_n", 1'b1, sdo_oe_n);
        end
        repeat (4) @(negedge clk_sys);
        test_done();
    end
endmodule

`default_nettype wire
